// file: hw/cbm_pkg.sv
package cbm_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned CLK_NS = 5;

    // times as printed, counts derived
    localparam int unsigned OVP_WAIT_MS = 30;
    localparam int unsigned OVP_WAIT_CYC = OVP_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned STAT_PULSE_US = 128;
    localparam int unsigned STAT_PULSE_CYC = STAT_PULSE_US * (CLK_HZ / 1000000);
    localparam int unsigned LIN_TIME_US = 560;
    localparam int unsigned LIN_CYC = LIN_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned SS1_TIME_US = 128;
    localparam int unsigned SS1_CYC = SS1_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned SS2_TIME_US = 384;
    localparam int unsigned SS2_CYC = SS2_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned ILIM_TIME_US = 50;
    localparam int unsigned ILIM_CYC = ILIM_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned DETECT_DONE_MS = 500;
    localparam int unsigned DETECT_DONE_CYC = DETECT_DONE_MS * (CLK_HZ / 1000);
    localparam int unsigned WDOG_S = 32;
    localparam int unsigned FIFTEEN_MIN_S = 900;
    localparam int unsigned RESTART_MS = 2000;
    localparam int unsigned DETECT_US = 100;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_SENSE = 8'h0C;

    // control register fields
    localparam int unsigned CTRL_KICK = 0;
    localparam int unsigned CTRL_HIZ = 1;
    localparam int unsigned CTRL_BOOST = 2;
    localparam int unsigned CTRL_RESET = 3;
    localparam int unsigned CTRL_STATEN = 4;
    localparam int unsigned CTRL_TE = 5;
    localparam int unsigned CTRL_CEN = 6;
    localparam int unsigned CTRL_PRODUCTION_TEST_SELECT = 7;
    localparam int unsigned CTRL_EOC = 8;
    localparam int unsigned CTRL_ILIM_LO = 9;
    localparam int unsigned CTRL_ILIM_HI = 10;
    localparam int unsigned CTRL_START = 11;
    localparam logic [11:0] CTRL_RESET_VAL = 12'h000;

    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_OVP = 3'h1;
    localparam logic [2:0] FLT_SS = 3'h2;
    localparam logic [2:0] FLT_UVLO = 3'h3;
    localparam logic [2:0] FLT_BATOV = 3'h4;
    localparam logic [2:0] FLT_THERM = 3'h5;
    localparam logic [2:0] FLT_TIMER = 3'h6;
    localparam logic [2:0] FLT_NO_BATTERY_FLAG = 3'h7;

    localparam logic [1:0] ST_READY = 2'h0;
    localparam logic [1:0] ST_CHARGING = 2'h1;
    localparam logic [1:0] ST_DONE = 2'h2;
    localparam logic [1:0] ST_FAULT = 2'h3;

    typedef enum logic [2:0] {
        CBM_OFF, CBM_LIN, CBM_SS1, CBM_SS2, CBM_BST
    } cbm_boost_t;

    typedef enum logic [1:0] {
        CBM_CHG, CBM_DETECT, CBM_WAIT
    } cbm_det_t;
endpackage

// file: hw/cbm_controller.sv
`timescale 1ns/100ps
`default_nettype none
module cbm_controller
    import cbm_pkg::*;
#(
    parameter int unsigned WDOG_CYC = WDOG_S * CLK_HZ,
    parameter int unsigned FIFTEEN_CYC = 32'hFFFFFFFF,
    parameter int unsigned RESTART_CYC = RESTART_MS * (CLK_HZ / 1000),
    parameter int unsigned DETECT_CYC = DETECT_US * (CLK_HZ / 1000000),
    parameter int unsigned OVP_CYC = OVP_WAIT_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic disable_pin,
    input wire logic pwm_pulse,
    input wire logic bat_above_target,
    input wire logic charge_terminated,
    input wire logic bat_above_recharge,
    input wire logic bat_below_short,
    input wire logic bat_below_lowv,
    input wire logic bat_above_boost_uvlo,
    input wire logic node_near_battery,
    input wire logic out_within_5pct,
    input wire logic out_above_95pct,
    input wire logic feedback_above_ref,
    input wire logic boost_current_limit,
    input wire logic input_overvoltage,
    input wire logic thermal_shutdown,
    output logic status_pin_o,
    output logic status_pin_oe_n,
    output logic charge_enable,
    output logic battery_switch,
    output logic second_battery_switch,
    output logic detect_discharge,
    output logic precharge_on,
    output logic precharge_30ma,
    output logic gate_drive,
    output logic aux_loops_en,
    output logic force_4v2,
    output logic boost_enable,
    output logic boost_switch_allow,
    output logic boost_full_limit,
    output logic node_source_on,
    output logic production_test_mode
);
    logic [11:0] ctrl;
    logic [2:0] fault;
    logic [1:0] status;
    logic no_battery_flag;
    logic fault_evt;
    logic [2:0] fault_code_evt;
    logic [1:0] status_evt;
    logic [31:0] wdog_cnt, fifteen_cnt, ovp_cnt, det_cnt, tmr;
    logic [15:0] pulse_cnt;
    logic [15:0] bst_cnt;
    logic fifteen_mode;
    logic idle;
    cbm_boost_t boost_run_state;
    cbm_det_t det;
    logic wr, rd, hiz, wdog_ovf, chg_ok, reg_reset, bst_fault;
    logic [2:0] bst_code;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign hiz = ctrl[CTRL_HIZ] || disable_pin;
    assign wdog_ovf = wdog_cnt >= WDOG_CYC - 1;
    assign chg_ok = !hiz && !ctrl[CTRL_CEN] && !idle;
    // long timer expiry resets registers while boost runs or the battery is below bat_below_lowv
    assign reg_reset = wdog_ovf && (boost_run_state != CBM_OFF || bat_below_lowv);

    // apb slave, answers in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CTRL
                && paddr != REG_STATUS && paddr != REG_CONFIG
                && paddr != REG_SENSE;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    REG_CTRL: prdata <= {20'h00000, ctrl};
                    REG_STATUS: prdata <= {24'h000000, no_battery_flag,
                        status, fault, production_test_mode, boost_enable};
                    REG_CONFIG: prdata <= {29'h00000000, idle,
                        fifteen_mode, det == CBM_WAIT};
                    REG_SENSE: prdata <= {29'h00000000, boost_run_state == CBM_BST,
                        boost_run_state == CBM_LIN, boost_run_state == CBM_SS1 || boost_run_state == CBM_SS2};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= CTRL_RESET_VAL;
        else if (wr && pready && paddr == REG_CTRL && pwdata[CTRL_RESET])
            ctrl <= CTRL_RESET_VAL;
        else if (reg_reset)
            ctrl <= CTRL_RESET_VAL;
        else if (wr && pready && paddr == REG_CTRL)
            ctrl <= pwdata[11:0] & 12'h7F6;
        else
        begin
            if (bst_fault)
                ctrl[CTRL_BOOST] <= 1'b0;
            if (det == CBM_DETECT && !bat_above_recharge)
            begin
                ctrl[CTRL_EOC] <= 1'b0;
                ctrl[CTRL_ILIM_HI:CTRL_ILIM_LO] <= 2'h0;
            end
        end
    end

    // long watchdog and fifteen-minute timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_cnt <= 32'h00000000;
            fifteen_cnt <= 32'h00000000;
            fifteen_mode <= 1'b0;
            idle <= 1'b0;
        end
        else
        begin
            if (wr && pready && paddr == REG_CTRL && pwdata[CTRL_KICK])
                wdog_cnt <= 32'h00000000;
            else if (wr && pready && paddr == REG_CTRL && pwdata[CTRL_RESET])
                wdog_cnt <= 32'h00000000;
            // restart on overflow so that expiry is a one-cycle event
            else if (reg_reset || wdog_ovf)
                wdog_cnt <= 32'h00000000;
            else if (disable_pin)
                wdog_cnt <= wdog_cnt;
            else if (!hiz || bat_below_lowv)
                wdog_cnt <= wdog_cnt + 32'h00000001;
            if (reg_reset && bat_below_lowv && !disable_pin && boost_run_state == CBM_OFF)
                fifteen_mode <= 1'b1;
            if (fifteen_mode && disable_pin)
                fifteen_cnt <= 32'h00000000;
            else if (fifteen_mode && chg_ok)
            begin
                fifteen_cnt <= fifteen_cnt + 32'h00000001;
                if (fifteen_cnt >= FIFTEEN_CYC - 1)
                begin
                    idle <= 1'b1;
                    fifteen_mode <= 1'b0;
                    fifteen_cnt <= 32'h00000000;
                end
            end
            if (wr && pready && paddr == REG_CTRL && pwdata[CTRL_START])
                idle <= 1'b0;
        end
    end

    // battery over-voltage wait and presence detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovp_cnt <= 32'h00000000;
            det <= CBM_CHG;
            det_cnt <= 32'h00000000;
            no_battery_flag <= 1'b0;
        end
        else
        begin
            if (pwm_pulse || !bat_above_target || !chg_ok)
                ovp_cnt <= 32'h00000000;
            else if (ovp_cnt < OVP_CYC)
                ovp_cnt <= ovp_cnt + 32'h00000001;
            if (reg_reset)
                no_battery_flag <= 1'b0;
            unique case (det)
                CBM_CHG:
                begin
                    det_cnt <= 32'h00000000;
                    if (charge_terminated && ctrl[CTRL_TE] && chg_ok)
                        det <= CBM_DETECT;
                end
                CBM_DETECT:
                begin
                    det_cnt <= det_cnt + 32'h00000001;
                    if (!bat_above_recharge)
                    begin
                        no_battery_flag <= 1'b1;
                        det <= CBM_WAIT;
                        det_cnt <= 32'h00000000;
                    end
                    else if (det_cnt >= DETECT_CYC - 1)
                    begin
                        no_battery_flag <= 1'b0;
                        det <= CBM_CHG;
                    end
                end
                CBM_WAIT:
                begin
                    det_cnt <= det_cnt + 32'h00000001;
                    if (det_cnt >= RESTART_CYC - 1)
                        det <= CBM_CHG;
                end
                default: det <= CBM_CHG;
            endcase
        end
    end

    // boost startup sequence
    always_comb
    begin
        bst_fault = 1'b0;
        bst_code = FLT_NONE;
        if (boost_run_state != CBM_OFF)
        begin
            if (wdog_ovf)
            begin
                bst_fault = 1'b1;
                bst_code = FLT_TIMER;
            end
            else if (thermal_shutdown)
            begin
                bst_fault = 1'b1;
                bst_code = FLT_THERM;
            end
            else if (input_overvoltage)
            begin
                bst_fault = 1'b1;
                bst_code = FLT_OVP;
            end
            else if (!bat_above_boost_uvlo)
            begin
                bst_fault = 1'b1;
                bst_code = FLT_UVLO;
            end
            else if ((boost_run_state == CBM_LIN && bst_cnt >= LIN_CYC - 1)
                || (boost_run_state == CBM_SS2 && bst_cnt >= SS2_CYC - 1)
                || (boost_run_state == CBM_BST && bst_cnt >= ILIM_CYC - 1))
            begin
                bst_fault = 1'b1;
                bst_code = FLT_SS;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boost_run_state <= CBM_OFF;
            bst_cnt <= 16'h0000;
        end
        else if (bst_fault || !ctrl[CTRL_BOOST] || ctrl[CTRL_HIZ]
            || fifteen_mode)
        begin
            boost_run_state <= CBM_OFF;
            bst_cnt <= 16'h0000;
        end
        else
        begin
            bst_cnt <= bst_cnt + 16'h0001;
            unique case (boost_run_state)
                CBM_OFF:
                begin
                    bst_cnt <= 16'h0000;
                    if (bat_above_boost_uvlo)
                        boost_run_state <= CBM_LIN;
                end
                CBM_LIN:
                    if (node_near_battery)
                    begin
                        boost_run_state <= CBM_SS1;
                        bst_cnt <= 16'h0000;
                    end
                CBM_SS1:
                    if (out_within_5pct)
                        boost_run_state <= CBM_BST;
                    else if (bst_cnt >= SS1_CYC - 1)
                    begin
                        boost_run_state <= CBM_SS2;
                        bst_cnt <= 16'h0000;
                    end
                CBM_SS2:
                    if (out_above_95pct)
                    begin
                        boost_run_state <= CBM_BST;
                        bst_cnt <= 16'h0000;
                    end
                CBM_BST:
                    if (!boost_current_limit)
                        bst_cnt <= 16'h0000;
                default: boost_run_state <= CBM_OFF;
            endcase
        end
    end

    // fault events and codes
    always_comb
    begin
        fault_evt = 1'b0;
        fault_code_evt = FLT_NONE;
        status_evt = ST_FAULT;
        if (bst_fault)
        begin
            fault_evt = 1'b1;
            fault_code_evt = bst_code;
        end
        else if (ovp_cnt == OVP_CYC - 1)
        begin
            fault_evt = 1'b1;
            fault_code_evt = FLT_BATOV;
        end
        else if ((det == CBM_DETECT && !bat_above_recharge)
            || (det == CBM_WAIT && det_cnt >= RESTART_CYC - 1
            && no_battery_flag && !ctrl[CTRL_EOC]))
        begin
            fault_evt = 1'b1;
            fault_code_evt = FLT_NO_BATTERY_FLAG;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault <= FLT_NONE;
            status <= ST_READY;
        end
        else if (fault_evt)
        begin
            fault <= fault_code_evt;
            status <= status_evt;
        end
        else if (rd && pready && paddr == REG_STATUS)
            fault <= FLT_NONE;
        else if (det == CBM_DETECT && det_cnt >= DETECT_CYC - 1)
            status <= ST_DONE;
        else if (chg_ok && status == ST_READY)
            status <= ST_CHARGING;
    end

    // status pin one-shot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_cnt <= 16'h0000;
            status_pin_oe_n <= 1'b1;
        end
        else
        begin
            if (fault_evt)
                pulse_cnt <= 16'(STAT_PULSE_CYC);
            else if (pulse_cnt != 16'h0000)
                pulse_cnt <= pulse_cnt - 16'h0001;
            status_pin_oe_n <= !(fault_evt || pulse_cnt > 16'h0001
                || (ctrl[CTRL_STATEN] && chg_ok && status == ST_CHARGING));
        end
    end

    // power stage controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_pin_o <= 1'b0;
            charge_enable <= 1'b0;
            battery_switch <= 1'b0;
            second_battery_switch <= 1'b0;
            detect_discharge <= 1'b0;
            precharge_on <= 1'b0;
            precharge_30ma <= 1'b0;
            gate_drive <= 1'b1;
            aux_loops_en <= 1'b1;
            force_4v2 <= 1'b0;
            boost_enable <= 1'b0;
            boost_switch_allow <= 1'b0;
            boost_full_limit <= 1'b0;
            node_source_on <= 1'b0;
            production_test_mode <= 1'b0;
        end
        else
        begin
            status_pin_o <= 1'b0;
            production_test_mode <= ctrl[CTRL_PRODUCTION_TEST_SELECT] && no_battery_flag;
            charge_enable <= chg_ok && !(det == CBM_WAIT
                && !ctrl[CTRL_EOC]);
            battery_switch <= production_test_mode
                || (chg_ok && det == CBM_CHG);
            second_battery_switch <= production_test_mode;
            gate_drive <= !production_test_mode;
            aux_loops_en <= !production_test_mode;
            force_4v2 <= production_test_mode;
            detect_discharge <= det == CBM_DETECT;
            precharge_on <= chg_ok && bat_below_short;
            precharge_30ma <= ctrl[CTRL_ILIM_HI];
            boost_enable <= boost_run_state != CBM_OFF;
            node_source_on <= boost_run_state == CBM_LIN;
            boost_full_limit <= boost_run_state == CBM_SS2 || boost_run_state == CBM_BST
                || (boost_run_state == CBM_SS1 && out_within_5pct);
            boost_switch_allow <= (boost_run_state == CBM_SS1 || boost_run_state == CBM_SS2
                || (boost_run_state == CBM_BST && !feedback_above_ref));
        end
    end
endmodule
`default_nettype wire

// file: verification/cbm_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cbm_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic status_pin_o,
    input wire logic disable_pin,
    input wire logic charge_enable,
    input wire logic production_test_mode,
    input wire logic gate_drive,
    input wire logic aux_loops_en,
    input wire logic force_4v2,
    input wire logic feedback_above_ref,
    input wire logic boost_switch_allow,
    input wire logic boost_enable,
    input wire logic input_overvoltage,
    input wire logic thermal_shutdown
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_stat_only_low: assert property (!status_pin_o)
        else $error("status pin driven high");
    // allows for the one-cycle register between the pin and charge_enable
    chk_dis_stops_chg: assert property (disable_pin [*4] |-> !charge_enable)
        else $error("charging while disable pin high");
    chk_ptm_outputs: assert property (production_test_mode &&
        $past(production_test_mode) |-> !gate_drive && !aux_loops_en &&
        force_4v2)
        else $error("production test outputs wrong");
    chk_pfm_inhibit: assert property (feedback_above_ref [*3]
        |-> !boost_switch_allow)
        else $error("boost switch allowed above reference");
    chk_ovp_boost_off: assert property (boost_enable &&
        input_overvoltage [*2] |-> ##[1:4] !boost_enable)
        else $error("boost kept on in over-voltage");
    chk_therm_boost_off: assert property (boost_enable &&
        thermal_shutdown [*2] |-> ##[1:4] !boost_enable)
        else $error("boost kept on in thermal shutdown");
endmodule
bind cbm_controller cbm_chk cbm_chk_inst (.*);
`default_nettype wire

// file: verification/cbm_analog.sv
`timescale 1ns/100ps
`default_nettype none
module cbm_analog (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic boost_enable,
    input wire logic node_source_on,
    output logic node_near_battery,
    output logic out_within_5pct,
    output logic out_above_95pct,
    output logic feedback_above_ref
);
    logic [3:0] t;
    logic [2:0] ph;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            t <= 4'h0;
        else if (!boost_enable)
            t <= 4'h0;
        else if ((node_source_on || t != 4'h0) && t != 4'hF)
            t <= t + 4'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ph <= 3'h0;
        else
            ph <= ph + 3'h1;
    end
    // node only charges once the startup source has been turned on
    assign node_near_battery = t > 4'h3;
    assign out_above_95pct = t > 4'h8;
    assign out_within_5pct = t > 4'hA;
    // ripple about the reference so pulse skipping is exercised
    // high for several cycles in a row so the inhibit check can fire
    assign feedback_above_ref = out_within_5pct && ph >= 3'h3;
endmodule
`default_nettype wire

// file: verification/charger_boost_mode_controller_test.sv
`timescale 1ns/100ps
`default_nettype none
module charger_boost_mode_controller_test;
    import cbm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic disable_pin, pwm_pulse, bat_above_target, charge_terminated;
    logic bat_above_recharge, bat_below_short, bat_below_lowv;
    logic bat_above_boost_uvlo, node_near_battery, out_within_5pct;
    logic out_above_95pct, feedback_above_ref, boost_current_limit;
    logic input_overvoltage, thermal_shutdown, status_pin_o;
    logic status_pin_oe_n, charge_enable, battery_switch;
    logic second_battery_switch, detect_discharge, precharge_on;
    logic precharge_30ma, gate_drive, aux_loops_en, force_4v2;
    logic boost_enable, boost_switch_allow, boost_full_limit;
    logic node_source_on, production_test_mode;
    int mismatches = 0;
    int n_checks = 0;
    logic [2:0] fq[$] = '{FLT_OVP, FLT_THERM, FLT_UVLO, FLT_TIMER};

    cbm_controller #(.WDOG_CYC(200), .FIFTEEN_CYC(300), .RESTART_CYC(50),
        .DETECT_CYC(20), .OVP_CYC(40)) cbm_controller_inst (.*);
    cbm_analog cbm_analog_inst (.*);

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic timeout;
        chk(32'h0, 32'h1);
        stop_test();
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && s !== v; n++)
            @(posedge pclk);
        if (s !== v)
            timeout();
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
            timeout();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // counts the clock edges that see the pin pulled low
    task automatic pulse_len(output int n);
        wait_for(status_pin_oe_n, 1'b0, 400);
        for (n = 1; n < 30000; n++)
        begin
            @(posedge pclk);
            if (status_pin_oe_n !== 1'b0)
                break;
        end
    endtask

    initial
    begin
        logic [31:0] r;
        logic e;
        logic [7:0] s;
        int k;
        int n;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {disable_pin, pwm_pulse, bat_above_target, charge_terminated} = '0;
        {bat_above_recharge, bat_below_short, bat_below_lowv} = '0;
        {input_overvoltage, thermal_shutdown, boost_current_limit} = '0;
        bat_above_boost_uvlo = 1'b1;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        chk(r[11:0], CTRL_RESET_VAL);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        $display("register test done");
        s = 8'h1F;
        bat_below_short <= 1'b1;
        for (k = 0; k < 4; k++)
        begin
            s = lfsr(s);
            apb(1'b1, REG_CTRL, {21'h0, s[1:0], 9'h0}, r, e);
            repeat (3) @(posedge pclk);
            chk(precharge_on, 1'b1);
            chk(precharge_30ma, s[1]);
        end
        bat_below_short <= 1'b0;
        disable_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(charge_enable, 1'b0);
        disable_pin <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h2, r, e);
        repeat (3) @(posedge pclk);
        chk(charge_enable, 1'b0);
        $display("charge control test done");
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, REG_CTRL, 32'h5, r, e);
            wait_for(boost_enable, 1'b1, 100);
            repeat (30) @(posedge pclk);
            apb(1'b0, REG_SENSE, 32'h0, r, e);
            chk(r[2], 1'b1);
            chk(boost_full_limit, 1'b1);
            chk(node_source_on, 1'b0);
            input_overvoltage <= (k == 0);
            thermal_shutdown <= (k == 1);
            bat_above_boost_uvlo <= (k != 2);
            if (k < 3)
            begin
                pulse_len(n);
                chk(n, STAT_PULSE_CYC);
            end
            wait_for(boost_enable, 1'b0, 400);
            {input_overvoltage, thermal_shutdown} <= 2'b00;
            bat_above_boost_uvlo <= 1'b1;
            apb(1'b0, REG_STATUS, 32'h0, r, e);
            chk(r[4:2], fq[k]);
            apb(1'b0, REG_CTRL, 32'h0, r, e);
            chk(r[2], 1'b0);
            apb(1'b0, REG_STATUS, 32'h0, r, e);
            chk(r[4:2], FLT_NONE);
        end
        $display("boost fault test done");
        apb(1'b1, REG_CTRL, 32'h80, r, e);
        charge_terminated <= 1'b1;
        repeat (40) @(posedge pclk);
        chk(detect_discharge, 1'b0);
        apb(1'b1, REG_CTRL, 32'hA0, r, e);
        wait_for(detect_discharge, 1'b1, 100);
        chk(battery_switch, 1'b0);
        wait_for(production_test_mode, 1'b1, 1000);
        apb(1'b0, REG_STATUS, 32'h0, r, e);
        chk(r[4:2], FLT_NO_BATTERY_FLAG);
        chk(r[7], 1'b1);
        chk(r[1], 1'b1);
        chk({battery_switch, second_battery_switch}, 2'b11);
        chk({gate_drive, aux_loops_en, force_4v2}, 3'b001);
        $display("detection test done");
        stop_test();
    end
endmodule
`default_nettype wire
